// [asrc_ctrl.sv]
// host controller for an asynchronous 256k x 16 static memory
// assumes memory data pins resolve from DQ_OUT/DQ_OE outside
`timescale 1ns/1ps
`include "asrc_regs.svh"

module asrc_ctrl #(
    parameter int POWER_WAIT = `ASRC_POWER_WAIT_CYC
) (
    input  wire logic                     REF_CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     CLK_EN,
    input  wire logic                     REQ_VALID,
    output logic                          REQ_READY,
    input  wire asrc_pkg::asrc_req_t      REQ,
    output logic                          RSP_VALID,
    output logic [`ASRC_DATA_W-1:0]       RSP_DATA,
    input  wire logic                     RETAIN_REQ,
    output logic                          RETAIN_OK,
    output asrc_pkg::asrc_pins_t          PINS,
    output logic [`ASRC_DATA_W-1:0]       DQ_OUT,
    output logic                          DQ_OE,
    input  wire logic [`ASRC_DATA_W-1:0]  DQ_IN
);
    import asrc_pkg::*;

    if (POWER_WAIT < 1 || POWER_WAIT > 65535) begin : g_bad_wait
        $error("POWER_WAIT out of range");
    end

    // ------------------------------------------------------------
    // states and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER, ST_IDLE, ST_RSETUP, ST_RSTROBE,
        ST_WSETUP, ST_WSTROBE, ST_WEND, ST_RETAIN
    } asrc_state_t;

    asrc_state_t                state;
    asrc_state_t                next_state;
    asrc_req_t                  held;
    asrc_pins_t                 pins;
    logic [`ASRC_DATA_W-1:0]    dq_out;
    logic                       dq_oe;
    logic [`ASRC_DATA_W-1:0]    dq_s1;
    logic [`ASRC_DATA_W-1:0]    dq_s2;
    logic [`ASRC_DATA_W-1:0]    rsp_data;
    logic                       rsp_valid;
    logic                       load;
    logic [15:0]                load_count;
    logic [15:0]                power_cnt;
    logic                       power_done;
    logic                       step_done;

    // ------------------------------------------------------------
    // lane mask helper
    // ------------------------------------------------------------
    function automatic logic [`ASRC_DATA_W-1:0] lane_mask(
        input logic [1:0] lanes
    );
        lane_mask = {{8{lanes[`ASRC_LANE_HIGH_BIT]}},
                     {8{lanes[`ASRC_LANE_LOW_BIT]}}};
    endfunction : lane_mask

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire take_req  = (state == ST_IDLE) && REQ_VALID && !RETAIN_REQ;
    wire lanes_any = |REQ.lanes;

    assign REQ_READY = (state == ST_IDLE) && !RETAIN_REQ && CLK_EN;
    assign RSP_VALID = rsp_valid;
    assign RSP_DATA  = rsp_data;
    assign RETAIN_OK = (state == ST_RETAIN) && pins.chip_sel_n;
    assign PINS      = pins;
    assign DQ_OUT    = dq_out;
    assign DQ_OE     = dq_oe;

    assign load = (state == ST_IDLE && take_req && lanes_any) ||
                  (state == ST_WSETUP) || (state == ST_RSETUP);
    // read strobe also spans the two pin sync stages
    assign load_count = (state == ST_WSETUP)
                      ? 16'(`ASRC_WRITE_CYC - 1)
                      : 16'(`ASRC_READ_CYC + `ASRC_SYNC_CYC);

    asrc_wait #(
        .WIDTH (16)
    ) u_wait (
        .clk   (REF_CLK),
        .rst   (SYS_RST),
        .ce    (CLK_EN),
        .load  (load),
        .count (load_count),
        .done  (step_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_POWER: begin
                if (power_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (RETAIN_REQ) begin
                    next_state = ST_RETAIN;
                end else if (take_req && lanes_any) begin
                    next_state = REQ.write ? ST_WSETUP : ST_RSETUP;
                end
            end
            ST_RSETUP:   next_state = ST_RSTROBE;
            ST_RSTROBE: begin
                if (step_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WSETUP:   next_state = ST_WSTROBE;
            ST_WSTROBE: begin
                if (step_done) begin
                    next_state = ST_WEND;
                end
            end
            ST_WEND:     next_state = ST_IDLE;
            ST_RETAIN: begin
                if (!RETAIN_REQ) begin
                    next_state = ST_IDLE;
                end
            end
            default:     next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // power-up counter
    // ------------------------------------------------------------
    assign power_done = (power_cnt == 16'(POWER_WAIT - 1));

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            power_cnt <= 16'h0000;
        end else if (CLK_EN) begin
            if (state == ST_POWER && !power_done) begin
                power_cnt <= power_cnt + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // pin sequencing
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state     <= ST_POWER;
            held      <= '0;
            pins      <= '{addr: '0, chip_sel_n: 1'b1, out_en_n: 1'b1,
                           write_n: 1'b1, byte_lane_low_n: 1'b1,
                           byte_lane_high_n: 1'b1};
            dq_out    <= '0;
            dq_oe     <= 1'b0;
            rsp_data  <= '0;
            rsp_valid <= 1'b0;
        end else if (CLK_EN) begin
            state     <= next_state;
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take_req && lanes_any) begin
                        held      <= REQ;
                        // address first, select later
                        pins.addr <= REQ.addr;
                        dq_out    <= REQ.wdata;
                        pins.byte_lane_low_n  <= !REQ.lanes[0];
                        pins.byte_lane_high_n <= !REQ.lanes[1];
                    end
                end
                ST_RSETUP: begin
                    pins.chip_sel_n <= 1'b0;
                    pins.out_en_n   <= 1'b0;
                end
                ST_RSTROBE: begin
                    if (step_done) begin
                        rsp_data  <= dq_s2 & lane_mask(held.lanes);
                        rsp_valid <= 1'b1;
                        pins.chip_sel_n <= 1'b1;
                        pins.out_en_n   <= 1'b1;
                    end
                end
                ST_WSETUP: begin
                    // output enable kept high, data driven with strobe
                    pins.chip_sel_n <= 1'b0;
                    pins.write_n    <= 1'b0;
                    dq_oe           <= 1'b1;
                end
                ST_WSTROBE: begin
                    if (step_done) begin
                        pins.write_n    <= 1'b1;
                        pins.chip_sel_n <= 1'b1;
                    end
                end
                ST_WEND: begin
                    dq_oe <= 1'b0;
                    pins.byte_lane_low_n  <= 1'b1;
                    pins.byte_lane_high_n <= 1'b1;
                end
                default: begin
                end
            endcase
            if (state == ST_RSTROBE && step_done) begin
                pins.byte_lane_low_n  <= 1'b1;
                pins.byte_lane_high_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read data capture, two stages from the pins
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else if (CLK_EN) begin
            dq_s1 <= DQ_IN;
            dq_s2 <= dq_s1;
        end
    end

endmodule : asrc_ctrl

// [asrc_regs.svh]
// timing counts and field constants for the static memory controller
// assumes a 10 MHz controller clock (100 ns period)
`ifndef ASRC_REGS_SVH
`define ASRC_REGS_SVH

`define ASRC_CLK_PERIOD_NS        100
`define ASRC_POWER_WAIT_US        100
`define ASRC_POWER_WAIT_CYC       \
    ((`ASRC_POWER_WAIT_US * 1000) / `ASRC_CLK_PERIOD_NS)
`define ASRC_FLOAT_DELAY_NS       5
`define ASRC_DATA_SETUP_NS        5
`define ASRC_WRITE_MIN_NS         (`ASRC_FLOAT_DELAY_NS + `ASRC_DATA_SETUP_NS)
`define ASRC_WRITE_CYC            \
    ((`ASRC_WRITE_MIN_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_READ_ACCESS_NS       10
`define ASRC_READ_CYC             \
    ((`ASRC_READ_ACCESS_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_SYNC_CYC             2
`define ASRC_RETENTION_GAP_NS     0
`define ASRC_ADDR_W               18
`define ASRC_DATA_W               16
`define ASRC_LANE_LOW_BIT         0
`define ASRC_LANE_HIGH_BIT        1

`endif

// [asrc_pkg.sv]
// types for the static memory controller
// assumes asrc_regs.svh is on the include path
`include "asrc_regs.svh"

package asrc_pkg;

    // user request: address, write data, lane enables, direction
    typedef struct packed {
        logic [`ASRC_ADDR_W-1:0] addr;
        logic [`ASRC_DATA_W-1:0] wdata;
        logic [1:0]              lanes;
        logic                    write;
    } asrc_req_t;

    // memory pins driven by the controller
    typedef struct packed {
        logic [`ASRC_ADDR_W-1:0] addr;
        logic                    chip_sel_n;
        logic                    out_en_n;
        logic                    write_n;
        logic                    byte_lane_low_n;
        logic                    byte_lane_high_n;
    } asrc_pins_t;

endpackage : asrc_pkg

// [asrc_wait.sv]
// cycle counter that holds the read and write strobe lengths
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps

module asrc_wait #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] remain;

    assign done = (remain == '0);

    always_ff @(posedge clk) begin
        if (rst) begin
            remain <= '0;
        end else if (ce) begin
            if (load) begin
                remain <= count;
            end else if (!done) begin
                remain <= remain - 1'b1;
            end
        end
    end

endmodule : asrc_wait

// [asrc_sram.sv]
// behavioural static memory on the controller's pins
// assumes the bench resolves the data bus
`timescale 1ns/1ps
module asrc_sram (
    input  wire logic                 REF_CLK,
    input  wire asrc_pkg::asrc_pins_t PINS,
    input  wire logic [15:0]          DQ_W,
    output logic [15:0]               DQ_R
);
    import asrc_pkg::*;
    logic [15:0] mem [0:262143];
    logic [15:0] lat;
    logic [17:0] lat_a;
    logic [1:0]  lat_l;
    logic        flip = 1'b0;
    wire lo  = ~PINS.byte_lane_low_n;
    wire hi  = ~PINS.byte_lane_high_n;
    wire sel = ~PINS.chip_sel_n;
    wire wr  = sel & ~PINS.write_n & (lo | hi);
    wire rd  = sel & ~PINS.out_en_n & PINS.write_n;
    wire [15:0] q = rd ? mem[PINS.addr] : 16'h0000;
    always @(posedge REF_CLK) flip <= ~flip;
    always @* if (wr) begin
        lat = DQ_W;
        lat_a = PINS.addr;
        lat_l = {hi, lo};
    end
    always @(negedge wr) begin
        if (lat_l[0]) mem[lat_a][7:0] = lat[7:0];
        if (lat_l[1]) mem[lat_a][15:8] = lat[15:8];
    end
    // floating lanes toggle each cycle
    assign DQ_R[7:0]  = (rd & lo) ? q[7:0] : {8{flip}} ^ 8'h5a;
    assign DQ_R[15:8] = (rd & hi) ? q[15:8] : {8{flip}} ^ 8'ha5;
endmodule : asrc_sram

// [asrc_ctrl_checker.sv]
// assertions on the memory controller's ports
// assumes bound into asrc_ctrl, one clock
`timescale 1ns/1ps
`include "asrc_regs.svh"
module asrc_chk #(
    parameter int POWER_WAIT = 8
) (
    input wire logic                    REF_CLK,
    input wire logic                    SYS_RST,
    input wire logic                    CLK_EN,
    input wire logic                    REQ_VALID,
    input wire logic                    REQ_READY,
    input wire asrc_pkg::asrc_req_t     REQ,
    input wire logic                    RSP_VALID,
    input wire logic [`ASRC_DATA_W-1:0] RSP_DATA,
    input wire logic                    RETAIN_REQ,
    input wire logic                    RETAIN_OK,
    input wire asrc_pkg::asrc_pins_t    PINS,
    input wire logic [`ASRC_DATA_W-1:0] DQ_OUT,
    input wire logic                    DQ_OE,
    input wire logic [`ASRC_DATA_W-1:0] DQ_IN
);
    import asrc_pkg::*;
    int cnt;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) cnt <= 0;
        else if (CLK_EN && cnt < POWER_WAIT) cnt <= cnt + 1;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    sequence take_rd;
        REQ_VALID && REQ_READY && CLK_EN && !REQ.write && REQ.lanes != 2'b00;
    endsequence
    sequence wr_on;
        $fell(PINS.write_n);
    endsequence
    // ----------
    // properties
    // ----------
    a_power_wait: assert property (
        REQ_READY |-> cnt >= POWER_WAIT - 1)
        else $error("ready before power wait");
    a_write_gate: assert property (
        !PINS.write_n |-> !PINS.chip_sel_n
        && !(PINS.byte_lane_low_n && PINS.byte_lane_high_n))
        else $error("bad write");
    a_write_setup: assert property (
        wr_on |-> DQ_OE && $stable(DQ_OUT) && $stable(PINS.addr))
        else $error("write setup");
    a_write_end: assert property (
        wr_on |=> $rose(PINS.write_n) && $rose(PINS.chip_sel_n))
        else $error("write end");
    a_read_float: assert property (
        !PINS.out_en_n |-> !DQ_OE)
        else $error("bus fight");
    a_write_oe: assert property (
        !PINS.write_n |-> PINS.out_en_n)
        else $error("oe low in write");
    a_read_addr: assert property (
        $fell(PINS.chip_sel_n) |-> $stable(PINS.addr))
        else $error("addr moved");
    a_read_answer: assert property (
        take_rd |-> ##6 RSP_VALID)
        else $error("no read answer");
    a_retain_desel: assert property (
        RETAIN_OK |-> PINS.chip_sel_n && !DQ_OE)
        else $error("retain selected");
    a_retain_refuse: assert property (
        RETAIN_REQ |-> !REQ_READY)
        else $error("ready in retain");
endmodule : asrc_chk
bind asrc_ctrl asrc_chk #(.POWER_WAIT(POWER_WAIT)) asrc_chk_i (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RETAIN_REQ(RETAIN_REQ),
    .RETAIN_OK(RETAIN_OK), .PINS(PINS), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .DQ_IN(DQ_IN));

// [tb.sv]
// self-checking bench for asrc_ctrl with a memory model
// assumes asrc_sram and the checker are compiled first
`timescale 1ns/1ps
module tb;
    import asrc_pkg::*;
    localparam int PW = 8;
    logic        REF_CLK = 0;
    logic        SYS_RST = 1;
    logic        REQ_VALID = 0;
    logic        RETAIN_REQ = 0;
    logic        CLK_EN = 1;
    asrc_req_t   REQ = '0;
    logic        REQ_READY, RSP_VALID, RETAIN_OK, DQ_OE;
    asrc_pins_t  PINS;
    logic [15:0] RSP_DATA, DQ_OUT, dq_r;
    wire  [15:0] dq = DQ_OE ? DQ_OUT : dq_r;
    int          n_errors = 0;
    int          num_checks = 0;
    always #50 REF_CLK = ~REF_CLK;
    asrc_ctrl #(.POWER_WAIT(PW)) asrc_ctrl_i (.REF_CLK(REF_CLK),
        .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .RETAIN_REQ(RETAIN_REQ), .RETAIN_OK(RETAIN_OK),
        .PINS(PINS), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQ_IN(dq));
    asrc_sram asrc_sram_i (.REF_CLK(REF_CLK), .PINS(PINS), .DQ_W(dq),
        .DQ_R(dq_r));
    task check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task req(input logic w, input logic [17:0] a, input logic [15:0] d,
             input logic [1:0] l);
        @(negedge REF_CLK);
        REQ_VALID = 1'b1;
        REQ = '{addr: a, wdata: d, lanes: l, write: w};
        for (int i = 0; i < 50 && REQ_READY !== 1'b1; i++) @(negedge REF_CLK);
        check(REQ_READY, 1'b1);
        @(negedge REF_CLK);
        REQ_VALID = 1'b0;
    endtask : req
    task rd(input logic [17:0] a, input logic [1:0] l, input logic [15:0] e);
        req(1'b0, a, 16'h0000, l);
        for (int i = 0; i < 20 && RSP_VALID !== 1'b1; i++) @(negedge REF_CLK);
        check(RSP_VALID, 1'b1);
        check(RSP_DATA, e);
    endtask : rd
    // ---------
    // scenarios
    // ---------
    task t_power;
        int n;
        check(PINS.chip_sel_n & PINS.write_n & ~DQ_OE, 1'b1);
        SYS_RST = 1'b0;
        n = 0;
        while (REQ_READY !== 1'b1 && n < 100) begin
            @(negedge REF_CLK);
            n++;
        end
        check(16'(n), 16'(PW));
    endtask : t_power
    task t_lanes;
        req(1'b1, 18'h30001, 16'h1234, 2'b11);
        req(1'b1, 18'h00000, 16'h0f0f, 2'b11);
        rd(18'h30001, 2'b11, 16'h1234);
        req(1'b1, 18'h30001, 16'habcd, 2'b01);
        rd(18'h30001, 2'b11, 16'h12cd);
        rd(18'h30001, 2'b10, 16'h1200);
        req(1'b1, 18'h30001, 16'h56ef, 2'b10);
        rd(18'h30001, 2'b01, 16'h00cd);
        rd(18'h00000, 2'b11, 16'h0f0f);
    endtask : t_lanes
    task t_drop;
        req(1'b1, 18'h30001, 16'hffff, 2'b00);
        req(1'b0, 18'h30001, 16'h0000, 2'b00);
        repeat (10) begin
            @(negedge REF_CLK);
            check(RSP_VALID, 1'b0);
        end
        rd(18'h30001, 2'b11, 16'h56cd);
    endtask : t_drop
    task t_freeze;
        @(negedge REF_CLK);
        CLK_EN = 1'b0;
        REQ_VALID = 1'b1;
        REQ = '{addr: 18'h30001, wdata: 16'h0000, lanes: 2'b11, write: 1'b0};
        repeat (5) begin
            @(negedge REF_CLK);
            check({15'h0000, REQ_READY | ~PINS.chip_sel_n}, 16'h0000);
        end
        REQ_VALID = 1'b0;
        CLK_EN = 1'b1;
        rd(18'h30001, 2'b11, 16'h56cd);
    endtask : t_freeze
    task t_retain;
        RETAIN_REQ = 1'b1;
        for (int i = 0; i < 20 && RETAIN_OK !== 1'b1; i++) @(negedge REF_CLK);
        check({RETAIN_OK, PINS.chip_sel_n, REQ_READY}, 16'h0006);
        RETAIN_REQ = 1'b0;
        rd(18'h00000, 2'b01, 16'h000f);
    endtask : t_retain
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    initial begin
        #500000;
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge REF_CLK);
        t_power();
        t_lanes();
        t_drop();
        t_freeze();
        t_retain();
        stop_test();
    end
endmodule : tb
